// file: hdl/cgtp_consts.svh
`ifndef CGTP_CONSTS_SVH
`define CGTP_CONSTS_SVH

// ==========================================================
// register offsets
`define CGTP_OFS_CHAN_D 8'h31
`define CGTP_OFS_CHAN_C 8'h37
`define CGTP_OFS_CORR 8'h3D
`define CGTP_OFS_CUST_HI 8'h3F
`define CGTP_OFS_CUST_LO 8'h40
`define CGTP_OFS_DIG_EN 8'h42
`define CGTP_OFS_BURST 8'h44
// ==========================================================
// field positions and reset values
`define CGTP_CORR_BIT 5
`define CGTP_DIG_EN_BIT 3
`define CGTP_BURST_BIT 7
`define CGTP_REG_RST 8'h00
// ==========================================================
// pattern words and timing
`define CGTP_TOG11_A 14'h0555
`define CGTP_TOG11_B 14'h02AA
`define CGTP_TOG14_A 14'h1555
`define CGTP_TOG14_B 14'h2AAA
`define CGTP_RAMP11_DIV 3'h7
`define CGTP_MID14 14'h2000
`define CGTP_CORR_STEP 14'h0008
`define CGTP_GAIN_UNITY 12'h400
`endif

// file: hdl/cgtp_pkg.sv
package cgtp_pkg;
  typedef enum logic [2:0] {
    CGTP_PAT_NORMAL = 3'b000,
    CGTP_PAT_ZEROS = 3'b001,
    CGTP_PAT_ONES = 3'b010,
    CGTP_PAT_TOGGLE = 3'b011,
    CGTP_PAT_RAMP = 3'b100,
    CGTP_PAT_CUSTOM = 3'b101,
    CGTP_PAT_RSVD6 = 3'b110,
    CGTP_PAT_RSVD7 = 3'b111
  } cgtp_pat_e;

  // one channel's control register, bit 7 down to bit 0
  typedef struct packed {
    logic [3:0] fine_gain_code;
    logic gain_skip;
    cgtp_pat_e pattern_select;
  } cgtp_chan_cfg_s;

  typedef logic [13:0] cgtp_word_t;
endpackage : cgtp_pkg

// file: hdl/cgtp_chan_post.sv
`include "cgtp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cgtp_chan_post
  import cgtp_pkg::*;
#(
  parameter int NCH = 2,
  parameter int DW = 14
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // converted samples, offset binary, index 0 is channel C, 1 is D
  input wire logic [NCH-1:0][DW-1:0] samp_in,
  // processed output stream
  output logic [NCH-1:0][DW-1:0] samp_out
);
  // ==========================================================
  // configuration registers
  cgtp_chan_cfg_s cfg_ff [NCH];
  logic corr_sel_ff;
  logic dig_en_ff;
  logic burst_ff;
  logic [5:0] cust_hi_ff;
  logic [7:0] cust_lo_ff;
  logic [7:0] reg_rdata_ff;
  logic [7:0] nxt_rdata;
  logic [DW-1:0] cust_word;

  // the 14-bit word is split over two registers, shared by all lanes
  assign cust_word = {cust_hi_ff, cust_lo_ff};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      corr_sel_ff <= 1'b0;
      dig_en_ff <= 1'b0;
      burst_ff <= 1'b0;
      cust_hi_ff <= 6'h00;
      cust_lo_ff <= 8'h00;
    end else if (reg_wr) begin
      case (reg_addr)
        `CGTP_OFS_CORR: begin
          corr_sel_ff <= reg_wdata[`CGTP_CORR_BIT];
        end
        `CGTP_OFS_DIG_EN: begin
          dig_en_ff <= reg_wdata[`CGTP_DIG_EN_BIT];
        end
        `CGTP_OFS_BURST: begin
          burst_ff <= reg_wdata[`CGTP_BURST_BIT];
        end
        `CGTP_OFS_CUST_HI: begin
          cust_hi_ff <= reg_wdata[5:0];
        end
        `CGTP_OFS_CUST_LO: begin
          cust_lo_ff <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // read-back, data stand in the cycle after the strobe only
  always_comb begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `CGTP_OFS_CHAN_C: nxt_rdata = cfg_ff[0];
      `CGTP_OFS_CHAN_D: nxt_rdata = cfg_ff[NCH-1];
      `CGTP_OFS_CORR: nxt_rdata = {2'h0, corr_sel_ff, 5'h00};
      `CGTP_OFS_DIG_EN: nxt_rdata = {4'h0, dig_en_ff, 3'h0};
      `CGTP_OFS_BURST: nxt_rdata = {burst_ff, 7'h00};
      `CGTP_OFS_CUST_HI: nxt_rdata = {2'h0, cust_hi_ff};
      `CGTP_OFS_CUST_LO: nxt_rdata = cust_lo_ff;
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_ff <= 8'h00;
    end else begin
      reg_rdata_ff <= reg_rd ? nxt_rdata : 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_ff;

  // ==========================================================
  // gain multiplier, 10 fractional bits, 10^(code/40)
  function automatic logic [11:0] gain_mult(input logic [3:0] code);
    logic [11:0] m;
    m = `CGTP_GAIN_UNITY;
    case (code)
      4'h0: m = 12'h400;
      4'h1: m = 12'h43D;
      4'h2: m = 12'h47D;
      4'h3: m = 12'h4C1;
      4'h4: m = 12'h509;
      4'h5: m = 12'h555;
      4'h6: m = 12'h5A6;
      4'h7: m = 12'h5FC;
      4'h8: m = 12'h657;
      4'h9: m = 12'h6B7;
      4'hA: m = 12'h71D;
      4'hB: m = 12'h789;
      // codes above 6 dB are not defined; hold at 6 dB
      default: m = 12'h7FB;
    endcase
    return m;
  endfunction

  // ==========================================================
  // per-channel datapath, each lane reads only its own fields
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      localparam logic [7:0] OFS = (ch == 0) ? `CGTP_OFS_CHAN_C
                                             : `CGTP_OFS_CHAN_D;
      logic tog_ff;
      logic [2:0] div_ff;
      logic [DW-1:0] ramp_ff;
      logic [DW-1:0] out_ff;
      logic [DW-1:0] nxt_out;
      logic [DW-1:0] gained;
      logic [DW-1:0] corr;
      logic signed [DW:0] centred;
      logic signed [DW+13:0] prod;
      logic signed [DW+3:0] scaled;
      logic apply_gain;

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          cfg_ff[ch] <= `CGTP_REG_RST;
        end else if (reg_wr && reg_addr == OFS) begin
          cfg_ff[ch] <= reg_wdata;
        end
      end

      // toggle phase advances each sample while the pattern is chosen
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          tog_ff <= 1'b0;
        end else if (cfg_ff[ch].pattern_select == CGTP_PAT_TOGGLE) begin
          tog_ff <= ~tog_ff;
        end else begin
          tog_ff <= 1'b0;
        end
      end

      // ramp restarts at zero each time the pattern is selected
      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          ramp_ff <= '0;
          div_ff <= 3'h0;
        end else if (cfg_ff[ch].pattern_select != CGTP_PAT_RAMP) begin
          ramp_ff <= '0;
          div_ff <= 3'h0;
        end else if (burst_ff) begin
          ramp_ff <= ramp_ff + 14'h0001;
          div_ff <= 3'h0;
        end else begin
          div_ff <= div_ff + 3'h1;
          if (div_ff == `CGTP_RAMP11_DIV) begin
            // 11 bits wrap from 2047 back to 0
            ramp_ff <= {3'h0, 11'(ramp_ff[10:0] + 11'h001)};
          end
        end
      end

      // gain acts only with the global enable and bypass clear
      assign apply_gain = dig_en_ff && !cfg_ff[ch].gain_skip;
      assign centred = $signed({1'b0, samp_in[ch]})
                     - $signed({1'b0, `CGTP_MID14});
      assign prod = centred * $signed({1'b0, gain_mult(
                      cfg_ff[ch].fine_gain_code)});
      assign scaled = prod[DW+13:10];

      always_comb begin
        gained = samp_in[ch];
        if (apply_gain) begin
          if (scaled > $signed(18'sd8191)) begin
            gained = 14'h3FFF;
          end else if (scaled < -$signed(18'sd8192)) begin
            gained = 14'h0000;
          end else begin
            gained = 14'(scaled) ^ `CGTP_MID14;
          end
        end
      end

      // mid-scale shift of one 11-bit LSB, clamped at zero
      always_comb begin
        corr = gained;
        if (dig_en_ff && corr_sel_ff && !burst_ff) begin
          corr = (gained < `CGTP_CORR_STEP) ? 14'h0000
               : 14'(gained - `CGTP_CORR_STEP);
        end
      end

      always_comb begin
        nxt_out = '0;
        case (cfg_ff[ch].pattern_select)
          CGTP_PAT_NORMAL: begin
            nxt_out = burst_ff ? corr : {3'h0, corr[13:3]};
          end
          CGTP_PAT_ZEROS: nxt_out = 14'h0000;
          CGTP_PAT_ONES: nxt_out = burst_ff ? 14'h3FFF : 14'h07FF;
          CGTP_PAT_TOGGLE: begin
            if (burst_ff) begin
              nxt_out = tog_ff ? `CGTP_TOG14_B : `CGTP_TOG14_A;
            end else begin
              nxt_out = tog_ff ? `CGTP_TOG11_B : `CGTP_TOG11_A;
            end
          end
          CGTP_PAT_RAMP: nxt_out = ramp_ff;
          CGTP_PAT_CUSTOM: begin
            nxt_out = burst_ff ? cust_word
                               : {3'h0, cust_word[13:3]};
          end
          // unused codes: output held at zero
          default: nxt_out = 14'h0000;
        endcase
      end

      always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
          out_ff <= '0;
        end else begin
          out_ff <= nxt_out;
        end
      end

      assign samp_out[ch] = out_ff;
    end
  endgenerate
endmodule : cgtp_chan_post
`default_nettype wire

// file: sim/cgtp_chan_post_checker.sv
`include "cgtp_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cgtp_chan_post_checker
  import cgtp_pkg::*;
#(
  parameter int NCH = 2,
  parameter int DW = 14
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // sample stream
  input wire logic [NCH-1:0][DW-1:0] samp_in,
  input wire logic [NCH-1:0][DW-1:0] samp_out
);
  // ==========================================================
  // shadow of the writes, so outputs are judged from the bus alone
  logic [7:0] c_ff, d_ff, hi_ff, lo_ff, en_ff, bm_ff;
  logic [2:0] pc, pd;
  logic bm;
  assign pc = c_ff[2:0];
  assign pd = d_ff[2:0];
  assign bm = bm_ff[`CGTP_BURST_BIT];
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      {c_ff, d_ff, hi_ff, lo_ff, en_ff, bm_ff} <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `CGTP_OFS_CHAN_C: c_ff <= reg_wdata;
        `CGTP_OFS_CHAN_D: d_ff <= reg_wdata;
        `CGTP_OFS_CUST_HI: hi_ff <= reg_wdata;
        `CGTP_OFS_CUST_LO: lo_ff <= reg_wdata;
        `CGTP_OFS_DIG_EN: en_ff <= reg_wdata;
        `CGTP_OFS_BURST: bm_ff <= reg_wdata;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  zeros_d_a: assert property (
    $past(pd) == CGTP_PAT_ZEROS |-> samp_out[1] == '0)
    else $error("channel D zeros pattern not low");
  tog11_alt_a: assert property (
    $past(pc, 2) == CGTP_PAT_TOGGLE && $past(pc) == CGTP_PAT_TOGGLE &&
    !$past(bm) && !$past(bm, 2) |->
    (samp_out[0] ^ $past(samp_out[0])) == 14'h07FF)
    else $error("11-bit toggle does not alternate");
  tog14_alt_a: assert property (
    $past(pc, 2) == CGTP_PAT_TOGGLE && $past(pc) == CGTP_PAT_TOGGLE &&
    $past(bm) && $past(bm, 2) |->
    (samp_out[0] ^ $past(samp_out[0])) == 14'h3FFF)
    else $error("14-bit toggle does not alternate");
  ramp11_step_a: assert property (
    $past(pc, 2) == CGTP_PAT_RAMP && $past(pc) == CGTP_PAT_RAMP &&
    !$past(bm) && !$past(bm, 2) |-> samp_out[0][13:11] == 3'h0 &&
    samp_out[0][10:0] - $past(samp_out[0][10:0]) <= 11'h001)
    else $error("11-bit ramp steps wrongly");
  ramp14_step_a: assert property (
    $past(pc, 2) == CGTP_PAT_RAMP && $past(pc) == CGTP_PAT_RAMP &&
    $past(bm) && $past(bm, 2) |->
    samp_out[0] == $past(samp_out[0]) + 14'h0001)
    else $error("14-bit ramp not one step per cycle");
  custom14_a: assert property (
    $past(pc) == CGTP_PAT_CUSTOM && $past(bm) |->
    samp_out[0] == {$past(hi_ff[5:0]), $past(lo_ff)})
    else $error("14-bit custom word wrong");
  skip14_a: assert property (
    $past(c_ff[3]) && $past(pc) == CGTP_PAT_NORMAL && $past(bm) |->
    samp_out[0] == $past(samp_in[0]))
    else $error("bypassed sample altered");
  readback_a: assert property (
    reg_rd && reg_addr == `CGTP_OFS_CHAN_C |=> reg_rdata == $past(c_ff))
    else $error("channel C register reads wrong");
endmodule : cgtp_chan_post_checker
`default_nettype wire

// file: sim/cgtp_lvds_rx.sv
`timescale 1ns/1ps
`default_nettype none
module cgtp_lvds_rx (
  // capture clock
  input wire logic clk_sys,
  // words from the block
  input wire logic [1:0][13:0] word_in,
  output logic [1:0][13:0] word_ff
);
  // latch on the edge after launch, as a capture register would
  always_ff @(posedge clk_sys) begin
    word_ff <= word_in;
  end
endmodule : cgtp_lvds_rx
`default_nettype wire

// file: sim/tb_channel_gain_and_test_pattern.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_channel_gain_and_test_pattern
  import cgtp_pkg::*;
;
  logic clk_sys = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [1:0][13:0] samp_in = '0, samp_out, cap;
  int error_cnt = 0, n_compared = 0;
  // first and second word per code, 11-bit then 14-bit
  cgtp_word_t e1 [10] = '{14'h0000, 14'h07FF, 14'h0555, 14'h0000, 14'h05B6,
    14'h0000, 14'h3FFF, 14'h1555, 14'h0000, 14'h2DB6};
  cgtp_word_t e2 [10] = '{14'h0000, 14'h07FF, 14'h02AA, 14'h0000, 14'h05B6,
    14'h0000, 14'h3FFF, 14'h2AAA, 14'h0001, 14'h2DB6};
  always #20 clk_sys = ~clk_sys;
  cgtp_chan_post #(.NCH(2), .DW(14)) cgtp_chan_post_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .samp_in(samp_in), .samp_out(samp_out));
  cgtp_lvds_rx cgtp_lvds_rx_inst (.clk_sys(clk_sys), .word_in(samp_out),
    .word_ff(cap));
  // ==========================================================
  // bus and stream helpers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask : rd
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : look
  task automatic drive(input logic [1:0][13:0] s);
    @(posedge clk_sys);
    samp_in <= s;
    look(2);
  endtask : drive
  // ==========================================================
  // scenarios
  task automatic t_reset();
    drive({14'h0100, 14'h1238});
    `CHK(cap, {14'h0020, 14'h0247})
    rd(8'h37, 8'h00);
    rd(8'h31, 8'h00);
    rd(8'h3D, 8'h00);
    rd(8'h00, 8'h00);
  endtask : t_reset
  task automatic t_regs();
    wr(8'h3D, 8'hFF);
    rd(8'h3D, 8'h20);
    wr(8'h37, 8'hA5);
    rd(8'h37, 8'hA5);
    wr(8'h31, 8'h01);
    rd(8'h31, 8'h01);
  endtask : t_regs
  task automatic t_patterns();
    wr(8'h3F, 8'h2D);
    wr(8'h40, 8'hB6);
    for (int i = 0; i < 10; i++) begin
      wr(8'h44, (i < 5) ? 8'h00 : 8'h80);
      wr(8'h37, 8'(i % 5 + 1));
      look(2);
      `CHK(cap[0], e1[i])
      look(1);
      `CHK(cap[0], e2[i])
      `CHK(cap[1], 14'h0000)
    end
  endtask : t_patterns
  task automatic t_ramp11();
    wr(8'h44, 8'h00);
    wr(8'h37, 8'h04);
    look(9);
    `CHK(cap[0], 14'h0000)
    look(1);
    `CHK(cap[0], 14'h0001)
  endtask : t_ramp11
  task automatic t_gain();
    wr(8'h44, 8'h80);
    wr(8'h37, 8'hC0);
    drive({14'h0000, 14'h3F00});
    `CHK(cap[0], 14'h3F00)
    wr(8'h42, 8'h08);
    wr(8'h31, 8'h02);
    wr(8'h37, 8'h80);
    drive({14'h0000, 14'h23E8});
    `CHK(cap[0], 14'h2000 + 14'((1000 * 1623) >> 10))
    `CHK(cap[1], 14'h3FFF)
    wr(8'h37, 8'hC0);
    drive({14'h0000, 14'h3F00});
    `CHK(cap[0], 14'h3FFF)
    wr(8'h37, 8'hC8);
    look(2);
    `CHK(cap[0], 14'h3F00)
  endtask : t_gain
  task automatic t_corr();
    wr(8'h44, 8'h00);
    wr(8'h37, 8'h00);
    wr(8'h31, 8'h00);
    drive({2{14'h2000}});
    `CHK(cap, {2{14'((14'h2000 - 14'h0008) >> 3)}})
  endtask : t_corr
  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_regs();
    t_patterns();
    t_ramp11();
    t_gain();
    t_corr();
    report_and_stop();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb_channel_gain_and_test_pattern
bind cgtp_chan_post cgtp_chan_post_checker #(.NCH(NCH), .DW(DW)) chk_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .samp_in(samp_in), .samp_out(samp_out));
`default_nettype wire
